// file: rtl/acs_regs.svh
/*
 * Offsets, field positions, reset values and timing counts of the conversion sequencer.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ACS_OFF_CFG0 12'h000
`define ACS_OFF_CHSEL 12'h004
`define ACS_OFF_DATA_BASE 12'h040
`define ACS_OFF_DATA_LAST 12'h07C

// ****************************************************************
// Field positions
// ****************************************************************
`define ACS_CFG0_AUTO 0
`define ACS_CFG0_RANGE2X 1
`define ACS_CFG0_BUSY 2
`define ACS_CFG0_READY 7
`define ACS_CFG0_SOFTCONV 15
`define ACS_CHSEL_DIFF0 16
`define ACS_CHSEL_DIFF1 17

// ****************************************************************
// Reset values
// ****************************************************************
`define ACS_RST_CHMASK 16'h0000
`define ACS_RST_DIFF 2'h0
`define ACS_RST_RESULT 12'h000

// ****************************************************************
// Timing
// ****************************************************************
`define ACS_CLK_KHZ 20000
`define ACS_SAMPLE_RATE_KSPS 500
`define ACS_SLOT_CYCLES (`ACS_CLK_KHZ / `ACS_SAMPLE_RATE_KSPS)
`define ACS_READY_PULSE_US 1
`define ACS_READY_PULSE_CYCLES (`ACS_READY_PULSE_US * `ACS_CLK_KHZ / 1000)

`endif

// file: rtl/acs_pkg.sv
/*
 * Types shared by the conversion sequencer modules.
 * Assumes the register header sits beside it.
 */
`include "acs_regs.svh"

package acs_pkg;

  // Sequencer states
  typedef enum logic [0:0] {
    ACS_IDLE,
    ACS_CONVERT
  } acs_state_t;

  // Channel index
  typedef logic [3:0] acs_chan_t;

  // One conversion result
  typedef logic [11:0] acs_result_t;

endpackage : acs_pkg

// file: rtl/acs_pin_sync.sv
/*
 * Three-stage synchroniser for an asynchronous pin with a falling-edge pulse.
 * Assumes the pin is quiet for longer than two clock periods around each change.
 */
`timescale 1ns/1ps

module acs_pin_sync (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic pin, // Asynchronous pin level
  output logic level, // Settled pin level
  output logic fall // One-cycle pulse on a settled falling edge
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Three flops; only stage1 feeds stage2
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      fall <= 1'b0;
      if (stage2 == stage3 && stage3 != level) begin
        level <= stage3;
        fall <= ~stage3;
      end
    end
  end

endmodule : acs_pin_sync

// file: rtl/acs_conv_seq.sv
/*
 * Conversion sequencer for a 16-channel SAR converter with an APB register file.
 * Assumes the analog front end converts the channel on afeChannel during each
 * slot and presents a settled code on afeData by the slot's last cycle.
 */
// The implementer's own choices: the placing of the registers and register access over APB.
// Behaviour
// - Sixteen channels, 0 to 15, share one converter at 500 kSPS.
// - Channels 4-15 single-ended; 0-3 four single or two differential pairs.
// - Range selectable between one and two times reference.
// - A differential pair converts only the difference, signed span.
// - Single-ended results straight binary, differential results two's complement.
// - Sequence starts on pin falling edge or software trigger bit write.
// - Enabled channels convert one after another, in ascending order.
// - A new software trigger abandons the current channel and restarts the sequence.
// - Pin trigger mid-channel lets the channel finish, then restarts the cycle.
// - Each finished channel result goes at once into its staging register.
// - After the last channel all staging registers copy into result registers.
// - Result registers hold while a host read of results is in progress.
// - Channel n result lands in result register n.
// - Direct mode: after the group, flag set and ready pin driven low.
// - Automatic mode: one 1 us low pulse on ready pin per pass.
`timescale 1ns/1ps
`include "acs_regs.svh"

module acs_conv_seq
  import acs_pkg::*;
#(
  parameter int SLOT_CYCLES = `ACS_SLOT_CYCLES,
  parameter int PULSE_CYCLES = `ACS_READY_PULSE_CYCLES
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_convert_trigger_n, // Convert trigger pin, falling edge
  output logic results_ready_n, // Results ready pin, active low
  output logic [3:0] afeChannel, // Channel under conversion
  output logic afeDiff, // Differential pairing for this slot
  output logic afeRange2x, // Doubled input range
  output logic afeSample, // One-cycle pulse starting a slot
  input wire logic [11:0] afeData // Raw code, offset binary when differential
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  acs_state_t state;
  acs_chan_t chan;
  logic [7:0] slotCnt;
  logic [7:0] pulseCnt;
  logic [15:0] chMask;
  logic [1:0] diffPair;
  logic autoMode;
  logic range2x;
  logic results_ready_flag;
  logic pinPending;
  logic copyPending;
  logic [11:0] staging_register [16];
  logic [11:0] result [16];
  logic pinFall;
  logic setupPhase;
  logic accessWrite;
  logic isData;
  logic hostXfer;
  logic dataRead;
  logic softTrig;
  logic anyTrig;
  logic slotEnd;
  logic lastChan;
  logic copyNow;
  logic [15:0] effMask;
  logic [4:0] firstChan;
  logic [4:0] followChan;
  logic [3:0] dataIdx;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Next enabled channel at or above start; bit 4 set when none
  function automatic logic [4:0] seekChan(input logic [15:0] mask, input logic [4:0] start);
    logic [4:0] found;
    found = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i] && 5'(i) >= start) begin
        found = 5'(i);
      end
    end
    return found;
  endfunction : seekChan

  // Differential slot when channel is the lower one of an enabled pair
  function automatic logic isDiffChan(input logic [3:0] ch, input logic [1:0] pairs);
    return (ch == 4'h0 && pairs[0]) || (ch == 4'h2 && pairs[1]);
  endfunction : isDiffChan

  // Offset binary becomes two's complement; single-ended stays straight
  function automatic logic [11:0] formatCode(input logic [11:0] raw, input logic diff);
    return diff ? {~raw[11], raw[10:0]} : raw;
  endfunction : formatCode

  // ****************************************************************
  // Trigger pin synchroniser
  // ****************************************************************
  acs_pin_sync u_trig_sync (
    .clk(clk),
    .reset(reset),
    .pin(ext_convert_trigger_n),
    .level(),
    .fall(pinFall)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // Phases, data window and trigger events
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign isData = paddr >= `ACS_OFF_DATA_BASE && paddr <= `ACS_OFF_DATA_LAST && paddr[1:0] == 2'h0;
  assign dataIdx = paddr[5:2];
  assign hostXfer = psel && !pwrite && isData;
  assign dataRead = hostXfer && penable;
  assign softTrig = accessWrite && paddr == `ACS_OFF_CFG0 && pwdata[`ACS_CFG0_SOFTCONV];
  assign anyTrig = softTrig || pinFall;
  assign pready = 1'b1;

  // Upper channel of a differential pair is folded into the lower one
  assign effMask = chMask & ~{12'h000, diffPair[1], 1'b0, diffPair[0], 1'b0};
  assign firstChan = seekChan(effMask, 5'h00);
  assign followChan = seekChan(effMask, 5'({1'b0, chan} + 5'h01));
  assign slotEnd = state == ACS_CONVERT && slotCnt == 8'(SLOT_CYCLES - 1);
  assign lastChan = followChan[4];
  assign copyNow = copyPending && !hostXfer;

  // Read data and error are captured in the setup phase
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      if (paddr == `ACS_OFF_CFG0) begin
        prdata[`ACS_CFG0_AUTO] <= autoMode;
        prdata[`ACS_CFG0_RANGE2X] <= range2x;
        prdata[`ACS_CFG0_BUSY] <= state == ACS_CONVERT;
        prdata[`ACS_CFG0_READY] <= results_ready_flag;
      end else if (paddr == `ACS_OFF_CHSEL) begin
        prdata <= {14'h0000, diffPair, chMask};
      end else if (isData) begin
        prdata <= {20'h00000, result[dataIdx]};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge clk) begin
    if (reset) begin
      autoMode <= 1'b0;
      range2x <= 1'b0;
      chMask <= `ACS_RST_CHMASK;
      diffPair <= `ACS_RST_DIFF;
    end else if (accessWrite) begin
      if (paddr == `ACS_OFF_CFG0) begin
        autoMode <= pwdata[`ACS_CFG0_AUTO];
        range2x <= pwdata[`ACS_CFG0_RANGE2X];
      end else if (paddr == `ACS_OFF_CHSEL) begin
        chMask <= pwdata[15:0];
        diffPair <= pwdata[`ACS_CHSEL_DIFF1:`ACS_CHSEL_DIFF0];
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Channel stepping, abort and repeat
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ACS_IDLE;
      chan <= 4'h0;
      slotCnt <= 8'h00;
      pinPending <= 1'b0;
      afeSample <= 1'b0;
    end else begin
      afeSample <= 1'b0;
      case (state)
        ACS_IDLE: begin
          pinPending <= 1'b0;
          if (anyTrig && !firstChan[4]) begin
            state <= ACS_CONVERT;
            chan <= firstChan[3:0];
            slotCnt <= 8'h00;
            afeSample <= 1'b1;
          end
        end
        ACS_CONVERT: begin
          slotCnt <= slotCnt + 8'h01;
          if (softTrig) begin
            pinPending <= 1'b0;
            slotCnt <= 8'h00;
            chan <= firstChan[3:0];
            afeSample <= !firstChan[4];
            if (firstChan[4]) begin
              state <= ACS_IDLE;
            end
          end else if (slotEnd) begin
            slotCnt <= 8'h00;
            pinPending <= 1'b0;
            if (pinPending || pinFall || (lastChan && autoMode)) begin
              chan <= firstChan[3:0];
              afeSample <= !firstChan[4];
              if (firstChan[4]) begin
                state <= ACS_IDLE;
              end
            end else if (lastChan) begin
              state <= ACS_IDLE;
            end else begin
              chan <= followChan[3:0];
              afeSample <= 1'b1;
            end
          end else if (pinFall) begin
            pinPending <= 1'b1;
          end
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // Front-end steering
  always_ff @(posedge clk) begin
    if (reset) begin
      afeChannel <= 4'h0;
      afeDiff <= 1'b0;
      afeRange2x <= 1'b0;
    end else begin
      afeChannel <= chan;
      afeDiff <= isDiffChan(chan, diffPair);
      afeRange2x <= range2x;
    end
  end

  // ****************************************************************
  // Double buffer
  // ****************************************************************

  // First stage takes each channel as it finishes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        staging_register[i] <= `ACS_RST_RESULT;
      end
    end else if (slotEnd && !softTrig) begin
      staging_register[chan] <= formatCode(afeData, isDiffChan(chan, diffPair));
    end
  end

  // Copy is requested at the end of a pass and deferred past host reads
  always_ff @(posedge clk) begin
    if (reset) begin
      copyPending <= 1'b0;
    end else if (slotEnd && !softTrig && !pinPending && !pinFall && lastChan) begin
      copyPending <= 1'b1;
    end else if (copyNow) begin
      copyPending <= 1'b0;
    end
  end

  // Second stage copies all channels at once
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        result[i] <= `ACS_RST_RESULT;
      end
    end else if (copyNow) begin
      for (int i = 0; i < 16; i++) begin
        result[i] <= staging_register[i];
      end
    end
  end

  // ****************************************************************
  // Results ready
  // ****************************************************************

  // Flag is set by a completed copy; set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      results_ready_flag <= 1'b0;
    end else if (copyNow) begin
      results_ready_flag <= 1'b1;
    end else if (dataRead || anyTrig) begin
      results_ready_flag <= 1'b0;
    end
  end

  // Pulse timer for automatic mode
  always_ff @(posedge clk) begin
    if (reset) begin
      pulseCnt <= 8'h00;
    end else if (copyNow && autoMode) begin
      pulseCnt <= 8'(PULSE_CYCLES);
    end else if (pulseCnt != 8'h00) begin
      pulseCnt <= pulseCnt - 8'h01;
    end
  end

  // Pin follows the flag in direct mode and the pulse in automatic mode
  always_ff @(posedge clk) begin
    if (reset) begin
      results_ready_n <= 1'b1;
    end else if (autoMode) begin
      results_ready_n <= !((copyNow) || pulseCnt > 8'h01);
    end else begin
      results_ready_n <= !(copyNow || (results_ready_flag && !(dataRead || anyTrig)));
    end
  end

endmodule : acs_conv_seq

// file: sim/acs_conv_seq_props.sv
/* Port checker for the conversion sequencer.
   Assumes it is bound into every acs_conv_seq instance. */
`timescale 1ns/1ps

module acs_conv_seq_props
  import acs_pkg::*;
#(
  parameter int SLOT_CYCLES = 40,
  parameter int PULSE_CYCLES = 20
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB data
  input wire logic results_ready_n, // Ready pin
  input wire logic [3:0] afeChannel, // Channel
  input wire logic afeDiff, // Pairing
  input wire logic afeRange2x, // Range
  input wire logic afeSample // Slot start
);
  logic [7:0] sinceSmp;
  logic [7:0] lowCnt;
  logic abortSeen;
  logic autoMode;
  logic wr0;
  logic rdData;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Decoded APB accesses
  assign wr0 = psel && penable && pwrite && paddr == 12'h000;
  assign rdData = psel && penable && !pwrite && paddr >= 12'h040 && paddr <= 12'h07C;
  // Cycles since the last slot start
  always_ff @(posedge clk) begin
    if (reset) sinceSmp <= 8'hFF;
    else if (afeSample) sinceSmp <= 8'h00;
    else if (sinceSmp != 8'hFF) sinceSmp <= sinceSmp + 8'h01;
  end
  // Software trigger seen in the current slot
  always_ff @(posedge clk) begin
    if (reset) abortSeen <= 1'b0;
    else if (wr0 && pwdata[15]) abortSeen <= 1'b1;
    else if (afeSample) abortSeen <= 1'b0;
  end
  // Mirror of the automatic-mode bit
  always_ff @(posedge clk) begin
    if (reset) autoMode <= 1'b0;
    else if (wr0) autoMode <= pwdata[0];
  end
  // Length of the current low stretch of the pin
  always_ff @(posedge clk) begin
    if (reset || results_ready_n) lowCnt <= 8'h00;
    else if (lowCnt != 8'hFF) lowCnt <= lowCnt + 8'h01;
  end
  a_slot_length: assert property (
    afeSample && !abortSeen |-> sinceSmp >= SLOT_CYCLES - 1) else $error("Slot too short");
  a_sample_single: assert property (
    afeSample |=> !afeSample) else $error("Slot start longer than one cycle");
  a_diff_chan: assert property (
    afeDiff && $stable(afeDiff) && $stable(afeChannel) |-> afeChannel inside {4'h0, 4'h2})
    else $error("Pairing on a wrong channel");
  a_range_write: assert property (
    $changed(afeRange2x) |-> $past(wr0) || $past(wr0, 2)) else $error("Range moved alone");
  a_soft_start: assert property (
    wr0 && pwdata[15] |-> ##[1:2] afeSample) else $error("Trigger without slot start");
  a_pulse_width: assert property (
    $rose(results_ready_n) && autoMode |-> lowCnt == PULSE_CYCLES)
    else $error("Ready pulse width wrong");
  a_ready_after: assert property (
    $fell(results_ready_n) && !autoMode |-> sinceSmp >= SLOT_CYCLES - 1)
    else $error("Ready before slot end");
  a_read_clears: assert property (
    rdData && !results_ready_n && !autoMode |=> results_ready_n)
    else $error("Ready kept after read");
endmodule : acs_conv_seq_props

bind acs_conv_seq acs_conv_seq_props #(.SLOT_CYCLES(SLOT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
  chk_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .results_ready_n(results_ready_n),
  .afeChannel(afeChannel), .afeDiff(afeDiff), .afeRange2x(afeRange2x),
  .afeSample(afeSample));

// file: sim/acs_afe_model.sv
/* Behavioural analog front end returning a code per channel.
   Assumes the sequencer drives the afe outputs from clk. */
`timescale 1ns/1ps

module acs_afe_model (
  input wire logic clk, // Clock
  input wire logic [3:0] afeChannel, // Channel
  input wire logic afeDiff, // Pairing
  input wire logic afeRange2x, // Range
  input wire logic afeSample, // Slot start
  output logic [11:0] afeData // Raw code
);
  logic [1:0] age;
  logic [11:0] code;
  // Code names channel, range and pairing; offset binary when paired
  assign code = {afeChannel, afeRange2x, afeDiff, 6'h2D};
  // Settling count since the slot began
  always_ff @(posedge clk) begin
    if (afeSample) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  // Unsettled early in a slot, so a too early sample reads wrong
  assign afeData = (age == 2'h3) ? code : ~code;
endmodule : acs_afe_model

// file: sim/adc_conversion_sequencer_tb.sv
/* Bench for the conversion sequencer: table of setups, then pin,
   abort, hold-off, auto, error and reset cases.
   Assumes design files, model and checker compile first. */
`timescale 1ns/1ps

module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  localparam int SLOT = 16;
  localparam int PULSE = 5;
  typedef struct {logic [15:0] mask; logic [1:0] pair; logic range;} acs_row_t;
  acs_row_t rows [4] = '{'{16'h0003, 2'h0, 1'b0}, '{16'h0005, 2'h1, 1'b1},
    '{16'hFFFF, 2'h3, 1'b0}, '{16'h8012, 2'h2, 1'b1}};
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, trigN = 1'b1, results_ready_n;
  logic afeDiff, afeRange2x, afeSample, seen = 1'b0;
  logic [3:0] afeChannel;
  logic [11:0] afeData;
  acs_result_t expRes [16] = '{default: 12'h000};
  acs_result_t old;
  acs_chan_t chanQ [$], expQ [$];
  int fail_count = 0, compares = 0, n;

  acs_conv_seq #(.SLOT_CYCLES(SLOT), .PULSE_CYCLES(PULSE)) dut_u (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_convert_trigger_n(trigN),
    .results_ready_n(results_ready_n), .afeChannel(afeChannel), .afeDiff(afeDiff),
    .afeRange2x(afeRange2x), .afeSample(afeSample), .afeData(afeData));
  acs_afe_model afe_u (.clk(clk), .afeChannel(afeChannel), .afeDiff(afeDiff),
    .afeRange2x(afeRange2x), .afeSample(afeSample), .afeData(afeData));

  // Clock
  initial forever #25 clk = ~clk;
  // Records the channel of each slot
  always @(negedge clk) begin
    if (seen) chanQ.push_back(afeChannel);
    seen = afeSample;
  end

  task automatic check(string what, logic [31:0] got, logic [31:0] want);
    compares++;
    if (got !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // One APB transfer; hold keeps psel up for a back-to-back transfer
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, bit hold = 1'b0);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic waitReady();
    for (int i = 0; i < 40 * SLOT && results_ready_n !== 1'b0; i++) @(negedge clk);
    check("ready", 32'(results_ready_n), 32'h0);
    @(posedge clk);
  endtask : waitReady

  // Expected order and results of one pass
  task automatic runPass(logic [15:0] mask, logic [1:0] pair, logic range);
    logic d;
    expQ.delete();
    for (int c = 0; c < 16; c++) begin
      if (mask[c] && !(c == 1 && pair[0]) && !(c == 3 && pair[1])) begin
        d = (c == 0 && pair[0]) || (c == 2 && pair[1]);
        expQ.push_back(acs_chan_t'(c));
        expRes[c] = {acs_chan_t'(c), range, d, 6'h2D} ^ {d, 11'h000};
      end
    end
  endtask : runPass

  task automatic readAll();
    for (int c = 0; c < 16; c++) begin
      apb(1'b0, 12'(64 + 4 * c), 32'h0);
      check("result", rd, {20'h0, expRes[c]});
    end
    @(negedge clk);
    check("cleared", 32'(results_ready_n), 32'h1);
    @(posedge clk);
  endtask : readAll

  task automatic doPass(logic [15:0] mask, logic [1:0] pair, logic range, bit again);
    logic [31:0] trig;
    trig = {16'h0, 1'b1, 13'h0, range, 1'b0};
    runPass(mask, pair, range);
    apb(1'b1, 12'h004, {14'h0, pair, mask});
    apb(1'b1, 12'h000, trig ^ 32'h00008000);
    @(negedge clk);
    check("range", 32'(afeRange2x), 32'(range));
    @(posedge clk);
    chanQ.delete();
    apb(1'b1, 12'h000, trig);
    if (again) begin
      repeat (3) @(posedge clk);
      apb(1'b1, 12'h000, trig);
      expQ.push_front(expQ[0]);
    end
    waitReady();
    readAll();
    check("order", 32'(chanQ == expQ), 32'h1);
  endtask : doPass

  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) doPass(rows[i].mask, rows[i].pair, rows[i].range, 1'b0);
    // Pin fall clears the flag; a second fall mid-slot restarts after the slot
    runPass(16'h0003, 2'h0, 1'b0);
    apb(1'b1, 12'h004, 32'h00000003);
    apb(1'b1, 12'h000, 32'h00008000);
    waitReady();
    apb(1'b0, 12'h000, 32'h0);
    check("flag", rd, 32'h00000080);
    chanQ.delete();
    expQ.push_front(4'h0);
    trigN <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("pinClear", 32'(results_ready_n), 32'h1);
    @(posedge clk);
    trigN <= 1'b1;
    repeat (3) @(posedge clk);
    trigN <= 1'b0;
    waitReady();
    readAll();
    check("pinOrder", 32'(chanQ == expQ), 32'h1);
    trigN <= 1'b1;
    doPass(16'h000C, 2'h2, 1'b1, 1'b1);
    // Back-to-back result reads hold off the copy
    old = expRes[0];
    runPass(16'h0001, 2'h0, 1'b1);
    apb(1'b1, 12'h004, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00008002);
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, 12'h040, 32'h0, k < 19);
      check("held", rd, {20'h0, old});
    end
    waitReady();
    readAll();
    // Automatic mode pulses each pass and stops when cleared
    apb(1'b1, 12'h004, 32'h00000003);
    apb(1'b1, 12'h000, 32'h00008001);
    waitReady();
    n = 0;
    while (results_ready_n === 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("pulse", n, PULSE);
    @(posedge clk);
    waitReady();
    apb(1'b1, 12'h000, 32'h0);
    repeat (3 * SLOT) @(posedge clk);
    chanQ.delete();
    repeat (3 * SLOT) @(posedge clk);
    check("stopped", chanQ.size(), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Reset in mid-conversion
    apb(1'b1, 12'h000, 32'h00008000);
    apb(1'b0, 12'h000, 32'h0);
    check("busy", rd, 32'h00000004);
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("rstReady", 32'(results_ready_n), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("rstMask", rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check("rstResult", rd, 32'h0);
    end_sim();
  end
endmodule : adc_conversion_sequencer_tb
